// ===== logic/clock_gen_pkg.sv
// Shared constants and carriers for the clock generator slices
package clock_gen_pkg;

    // Divisor layout: unsigned 24.8 fixed point
    localparam int DIV_INT_W  = 24;
    localparam int DIV_FRAC_W = 8;
    localparam int DIV_W      = DIV_INT_W + DIV_FRAC_W;
    localparam int DIV_INT_LSB = DIV_FRAC_W;

    // Smallest divisor that runs the counting divider; below it the slice passes its input through
    localparam logic [DIV_INT_W-1:0] DIV_MIN_COUNT = 24'h000002;

    // Source pins and slice counts
    localparam int NSRC     = 8;
    localparam int AUX_W    = NSRC + 2;
    localparam int SEL_W    = 4;
    localparam int NSL      = 10;
    localparam int NDEST    = 8;
    localparam int NCORE    = 2;

    // Source pin positions
    localparam int SRC_RING    = 0;
    localparam int SRC_CRYSTAL = 1;

    // Slice positions
    localparam int SL_REF    = 0;
    localparam int SL_SYS    = 1;
    localparam int SL_GPIO_A = 2;
    localparam int SL_GPIO_B = 3;
    localparam int SL_GPIO_C = 4;
    localparam int SL_GPIO_D = 5;

    // Destination positions with special gating
    localparam int DEST_BUSFABRIC = 0;
    localparam int DEST_CLOCKS    = 1;

    // Destinations that stay clocked whenever the system is awake
    localparam logic [NDEST-1:0] WAKE_FORCE = 8'h03;

    // Reset values
    localparam logic [NDEST-1:0] EN_RESET  = 8'hff;
    localparam logic [1:0]       SEL_PRIMARY = 2'h1;
    localparam logic [1:0]       SEL_AUX     = 2'h2;

    // Per-slice control word
    typedef struct packed {
        logic [SEL_W-1:0] aux_sel;
        logic             glitch_aux;
        logic             enable;
        logic             kill;
        logic             dcc_en;
        logic [DIV_W-1:0] div;
    } slice_ctrl_t;

endpackage

// ===== logic/clock_gen_slices.sv
// Clock generator slices with source muxes, fractional dividers and destination gating
`timescale 1ns/10ps
`default_nettype none

module clock_slice #(
    parameter bit GLITCHLESS = 1'b0,
    parameter bit ALWAYS_ON  = 1'b0
) (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               reset_n,
    input  wire logic                               ce,
    // Sources, already synchronised
    input  wire logic [clock_gen_pkg::AUX_W-1:0]    aux_src,
    input  wire logic                               primary_src,
    // Control
    input  wire clock_gen_pkg::slice_ctrl_t          ctrl,
    input  wire logic                               state_a,
    // Outputs
    output var  logic                               clk_out_r,
    output var  logic [1:0]                         selected_r
);

    // Divider state
    logic                                 in_r;
    logic                                 running_r;
    logic                                 bypass_r;
    logic                                 hold_r;
    logic                                 gm_off_r;
    logic [clock_gen_pkg::DIV_INT_W-1:0]  cnt_r;
    logic [clock_gen_pkg::DIV_INT_W:0]    len_r;
    logic [clock_gen_pkg::DIV_INT_W-1:0]  half_r;
    logic [clock_gen_pkg::DIV_FRAC_W-1:0] acc_r;

    logic                                 aux_lvl;
    logic                                 in_lvl;
    logic                                 rise;
    logic                                 fall;
    logic                                 en_req;
    logic                                 kill;
    logic [clock_gen_pkg::DIV_INT_W-1:0]  div_int;
    logic [clock_gen_pkg::DIV_FRAC_W-1:0] div_frac;
    logic [clock_gen_pkg::DIV_FRAC_W:0]   acc_sum;
    logic [clock_gen_pkg::DIV_INT_W:0]    len_nxt;
    logic [clock_gen_pkg::DIV_INT_W:0]    cnt_inc;
    logic                                 at_end;

    // Aux mux: plain select, glitches on a select change are tolerated here
    assign aux_lvl = (ctrl.aux_sel < clock_gen_pkg::SEL_W'(clock_gen_pkg::AUX_W)) ?
                     aux_src[ctrl.aux_sel] : 1'b0;
    // Always-on slices ignore the enable and kill fields entirely
    assign en_req = ALWAYS_ON ? !state_a : ctrl.enable;
    assign kill   = ALWAYS_ON ? 1'b0 : ctrl.kill;
    assign div_int  = ctrl.div[clock_gen_pkg::DIV_W-1:clock_gen_pkg::DIV_INT_LSB];
    assign div_frac = ctrl.div[clock_gen_pkg::DIV_FRAC_W-1:0];
    assign acc_sum  = {1'b0, acc_r} + {1'b0, div_frac};
    // Overflow of the fraction stretches this period by one input cycle
    assign len_nxt  = {1'b0, div_int} + {{clock_gen_pkg::DIV_INT_W{1'b0}}, acc_sum[clock_gen_pkg::DIV_FRAC_W]};
    assign cnt_inc  = {1'b0, cnt_r} + 25'h0000001;
    assign at_end   = (cnt_inc == len_r);

    // Glitch-free mux: park low on the old source, then join the new one while it is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            selected_r <= GLITCHLESS ? clock_gen_pkg::SEL_PRIMARY : 2'h0;
            gm_off_r   <= 1'b0;
        end else if (ce && GLITCHLESS) begin
            if (ctrl.glitch_aux != selected_r[1]) begin
                if (!in_lvl) begin
                    gm_off_r <= 1'b1;
                end
                if (gm_off_r && !(ctrl.glitch_aux ? aux_lvl : primary_src)) begin
                    selected_r <= ctrl.glitch_aux ? clock_gen_pkg::SEL_AUX : clock_gen_pkg::SEL_PRIMARY;
                    gm_off_r   <= 1'b0;
                end
            end else if (gm_off_r && !(selected_r[1] ? aux_lvl : primary_src)) begin
                // A withdrawn request must not leave the output parked for good
                gm_off_r <= 1'b0;
            end
        end
    end

    // Divider input level after the mux chain
    always_comb begin
        if (!GLITCHLESS) begin
            in_lvl = aux_lvl;
        end else if (gm_off_r) begin
            in_lvl = 1'b0;
        end else begin
            in_lvl = selected_r[1] ? aux_lvl : primary_src;
        end
    end

    assign rise = in_lvl && !in_r;
    assign fall = !in_lvl && in_r;
    // Edge history of the divider input
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_r <= 1'b0;
        end else if (ce) begin
            in_r <= in_lvl;
        end
    end
    // Divider: period decisions happen on input rising edges, or whenever the input sits low in bypass
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            running_r <= ALWAYS_ON;
            bypass_r  <= 1'b1;
            clk_out_r <= 1'b0;
            hold_r    <= 1'b0;
            cnt_r     <= '0;
            len_r     <= 25'h0000001;
            half_r    <= '0;
            acc_r     <= '0;
        end else if (ce) begin
            if (kill) begin
                // Forced stop cuts the output mid-cycle
                running_r <= 1'b0;
                clk_out_r <= 1'b0;
                hold_r    <= 1'b0;
                cnt_r     <= '0;
            end else if (bypass_r) begin
                // Divide by one: the cycle ends whenever the input sits low
                clk_out_r <= in_lvl && running_r;
                if (!in_lvl) begin
                    running_r <= en_req;
                    bypass_r  <= (div_int < clock_gen_pkg::DIV_MIN_COUNT);
                    len_r     <= len_nxt;
                    half_r    <= len_nxt[clock_gen_pkg::DIV_INT_W:1];
                    acc_r     <= acc_sum[clock_gen_pkg::DIV_FRAC_W-1:0];
                    cnt_r     <= '0;
                end
            end else if (rise && (!running_r || at_end)) begin
                // Period boundary: sample enable and divisor together
                running_r <= en_req;
                clk_out_r <= en_req;
                hold_r    <= 1'b0;
                cnt_r     <= '0;
                bypass_r  <= (div_int < clock_gen_pkg::DIV_MIN_COUNT);
                len_r     <= len_nxt;
                half_r    <= len_nxt[clock_gen_pkg::DIV_INT_W:1];
                acc_r     <= acc_sum[clock_gen_pkg::DIV_FRAC_W-1:0];
            end else if (rise) begin
                cnt_r <= cnt_inc[clock_gen_pkg::DIV_INT_W-1:0];
                if (cnt_inc[clock_gen_pkg::DIV_INT_W-1:0] == half_r) begin
                    // Odd divisors with correction wait for the next input fall
                    if (ctrl.dcc_en && len_r[0]) begin
                        hold_r <= 1'b1;
                    end else begin
                        clk_out_r <= 1'b0;
                    end
                end
            end else if (fall && hold_r) begin
                clk_out_r <= 1'b0;
                hold_r    <= 1'b0;
            end
        end
    end

    // Forced stop drops the output at once
    kill_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && kill |=> !clk_out_r && !running_r)
        else $error("kill did not stop the slice");
    // Divisor only reloads on a period boundary
    div_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !kill && !bypass_r && !(rise && (!running_r || at_end)) |=> $stable(len_r))
        else $error("divisor changed mid-cycle");
    // Enable only sampled at a period boundary
    enable_sync_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !kill && !bypass_r && running_r && !(rise && at_end) |=> running_r)
        else $error("slice stopped mid-cycle");
    // Uncorrected output falls on the rising edge reaching half the period
    duty_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !kill && !bypass_r && rise && running_r && !at_end
        && cnt_inc[clock_gen_pkg::DIV_INT_W-1:0] == half_r && !(ctrl.dcc_en && len_r[0]) |=> !clk_out_r)
        else $error("output did not fall at half period");
    // Corrected odd output stays high until the next input fall
    dcc_shift_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !kill && hold_r && !fall |=> clk_out_r)
        else $error("corrected output fell early");
    // Fraction overflow lengthens the loaded period by one
    frac_carry_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !kill && !bypass_r && rise && (!running_r || at_end) && acc_sum[clock_gen_pkg::DIV_FRAC_W]
        |=> len_r == {1'b0, $past(div_int)} + 25'h0000001)
        else $error("fraction carry not applied");
    // Selected status is one-hot and the mux output is parked while switching
    gm_status_a: assert property (@(posedge clk) disable iff (!reset_n)
        GLITCHLESS && $changed(selected_r) |-> $onehot(selected_r) && !$past(in_lvl))
        else $error("glitch-free switch while source high");

endmodule

module clock_gen_slices #(
    parameter int NSRC_P  = clock_gen_pkg::NSRC,
    parameter int NDEST_P = clock_gen_pkg::NDEST
) (
    // Clock and reset
    input  wire logic                                         clk,
    input  wire logic                                         reset_n,
    input  wire logic                                         ce,
    // Clock source pins
    input  wire logic [NSRC_P-1:0]                            src_clk_in,
    // Slice controls
    input  wire clock_gen_pkg::slice_ctrl_t [clock_gen_pkg::NSL-1:0] ctrl,
    input  wire logic                                         state_a_active,
    // Sleep inputs
    input  wire logic [clock_gen_pkg::NCORE-1:0]              core_sleep,
    input  wire logic                                         dma_busy,
    // Enable writes
    input  wire logic                                         wake_en_wr,
    input  wire logic                                         sleep_en_wr,
    input  wire logic [NDEST_P-1:0]                           en_wdata,
    // Slice outputs
    output var  logic [clock_gen_pkg::NSL-1:0]                slice_clk,
    output var  logic                                         gpio_clock_out_a,
    output var  logic                                         gpio_clock_out_b,
    output var  logic                                         gpio_clock_out_c,
    output var  logic                                         gpio_clock_out_d,
    output var  logic [1:0]                                   ref_selected,
    output var  logic [1:0]                                   sys_selected,
    // Distribution
    output var  logic                                         core_clk_r,
    output var  logic [NDEST_P-1:0]                           dest_clk_r,
    output var  logic [NDEST_P-1:0]                           dest_en_r,
    output var  logic [NDEST_P-1:0]                           wake_en_r,
    output var  logic [NDEST_P-1:0]                           sleep_en_r,
    output var  logic                                         sys_sleep_r
);

    logic [NSRC_P-1:0]               src_meta_r;
    logic [NSRC_P-1:0]               src_sync_r;
    logic [clock_gen_pkg::AUX_W-1:0] aux_vec;
    logic [NDEST_P-1:0]              wake_force;
    // Source pins are foreign clocks: two flops before any use
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            src_meta_r <= '0;
            src_sync_r <= '0;
        end else if (ce) begin
            src_meta_r <= src_clk_in;
            src_sync_r <= src_meta_r;
        end
    end
    // Aux candidates: source pins plus the two always-on outputs
    assign aux_vec = {slice_clk[clock_gen_pkg::SL_SYS], slice_clk[clock_gen_pkg::SL_REF],
                      clock_gen_pkg::NSRC'(src_sync_r)};
    // Reference slice starts on the ring oscillator
    clock_slice #(.GLITCHLESS(1'b1), .ALWAYS_ON(1'b1)) ref_slice (
        .clk         (clk),
        .reset_n     (reset_n),
        .ce          (ce),
        .aux_src     (aux_vec),
        .primary_src (src_sync_r[clock_gen_pkg::SRC_RING]),
        .ctrl        (ctrl[clock_gen_pkg::SL_REF]),
        .state_a     (state_a_active),
        .clk_out_r   (slice_clk[clock_gen_pkg::SL_REF]),
        .selected_r  (ref_selected)
    );
    // System slice starts on the reference clock
    clock_slice #(.GLITCHLESS(1'b1), .ALWAYS_ON(1'b1)) sys_slice (
        .clk         (clk),
        .reset_n     (reset_n),
        .ce          (ce),
        .aux_src     (aux_vec),
        .primary_src (slice_clk[clock_gen_pkg::SL_REF]),
        .ctrl        (ctrl[clock_gen_pkg::SL_SYS]),
        .state_a     (state_a_active),
        .clk_out_r   (slice_clk[clock_gen_pkg::SL_SYS]),
        .selected_r  (sys_selected)
    );
    // Aux-only slices; software must stop them before changing source
    for (genvar i = clock_gen_pkg::SL_GPIO_A; i < clock_gen_pkg::NSL; i++) begin : g_slice
        clock_slice #(.GLITCHLESS(1'b0), .ALWAYS_ON(1'b0)) u_slice (
            .clk         (clk),
            .reset_n     (reset_n),
            .ce          (ce),
            .aux_src     (aux_vec),
            .primary_src (1'b0),
            .ctrl        (ctrl[i]),
            .state_a     (1'b0),
            .clk_out_r   (slice_clk[i]),
            .selected_r  ()
        );
    end
    // GPIO clock outputs carry no destination gate
    assign gpio_clock_out_a = slice_clk[clock_gen_pkg::SL_GPIO_A];
    assign gpio_clock_out_b = slice_clk[clock_gen_pkg::SL_GPIO_B];
    assign gpio_clock_out_c = slice_clk[clock_gen_pkg::SL_GPIO_C];
    assign gpio_clock_out_d = slice_clk[clock_gen_pkg::SL_GPIO_D];
    // Enable registers; a write replaces the whole vector
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_en_r  <= NDEST_P'(clock_gen_pkg::EN_RESET);
            sleep_en_r <= NDEST_P'(clock_gen_pkg::EN_RESET);
        end else if (ce) begin
            if (wake_en_wr) begin
                wake_en_r <= en_wdata;
            end
            if (sleep_en_wr) begin
                sleep_en_r <= en_wdata;
            end
        end
    end
    // System sleep follows the cores and DMA each cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_sleep_r <= 1'b0;
        end else if (ce) begin
            sys_sleep_r <= (&core_sleep) && !dma_busy;
        end
    end
    // Fabric and clock-register destinations cannot be turned off while awake
    assign wake_force = NDEST_P'(clock_gen_pkg::WAKE_FORCE);
    // Gate selection and gated system clock to each destination
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dest_en_r  <= NDEST_P'(clock_gen_pkg::EN_RESET);
            dest_clk_r <= '0;
            core_clk_r <= 1'b0;
        end else if (ce) begin
            dest_en_r  <= sys_sleep_r ? sleep_en_r : (wake_en_r | wake_force);
            dest_clk_r <= dest_en_r & {NDEST_P{slice_clk[clock_gen_pkg::SL_SYS]}};
            core_clk_r <= slice_clk[clock_gen_pkg::SL_SYS];
        end
    end
    // Sleep entered one cycle after its conditions hold
    sleep_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && (&core_sleep) && !dma_busy |=> sys_sleep_r)
        else $error("system sleep not entered");
    // Gates follow the sleep enable set while the system sleeps
    gate_select_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && sys_sleep_r |=> dest_en_r == $past(sleep_en_r))
        else $error("sleep gating not applied");
    // Fabric stays clocked whenever awake
    fabric_awake_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !sys_sleep_r |=> dest_en_r[clock_gen_pkg::DEST_BUSFABRIC] && dest_en_r[clock_gen_pkg::DEST_CLOCKS])
        else $error("fabric gated while awake");

endmodule

`default_nettype wire

// ===== verif/clock_gen_slices_tb_top.sv
// Self-checking bench for the clock generator slices
`timescale 1ns/10ps
`default_nettype none

module clock_gen_slices_tb_top;
    `define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] src_clk_in = 8'h00;
    clock_gen_pkg::slice_ctrl_t [clock_gen_pkg::NSL-1:0] ctrl;
    logic state_a_active = 1'b0;
    logic [1:0] core_sleep = 2'h0;
    logic dma_busy = 1'b0;
    logic wake_en_wr = 1'b0;
    logic sleep_en_wr = 1'b0;
    logic [7:0] en_wdata = 8'h00;
    logic [9:0] slice_clk;
    logic gpo_a, core_clk_r, sys_sleep_r;
    logic [1:0] ref_selected, sys_selected;
    logic [7:0] dest_clk_r, dest_en_r, wake_en_r, sleep_en_r;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int scnt = 0;
    int hi, lo, hi2, lo2;

    // 4 ns clock; sources toggle every 8 cycles, giving a 16-cycle source period
    always #2 clk = ~clk;
    always @(negedge clk) begin
        scnt = (scnt == 7) ? 0 : scnt + 1;
        if (scnt == 0) src_clk_in <= ~src_clk_in;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            print_verdict();
        end
    end

    clock_gen_slices DUT (.clk(clk), .reset_n(reset_n), .ce(1'b1), .src_clk_in(src_clk_in), .ctrl(ctrl),
        .state_a_active(state_a_active), .core_sleep(core_sleep), .dma_busy(dma_busy),
        .wake_en_wr(wake_en_wr), .sleep_en_wr(sleep_en_wr), .en_wdata(en_wdata), .slice_clk(slice_clk),
        .gpio_clock_out_a(gpo_a), .gpio_clock_out_b(), .gpio_clock_out_c(), .gpio_clock_out_d(),
        .ref_selected(ref_selected), .sys_selected(sys_selected), .core_clk_r(core_clk_r),
        .dest_clk_r(dest_clk_r), .dest_en_r(dest_en_r), .wake_en_r(wake_en_r), .sleep_en_r(sleep_en_r),
        .sys_sleep_r(sys_sleep_r));

    task automatic print_verdict();
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Bounded wait until a slice output reaches a level
    task automatic wait_lvl(input int idx, input logic lvl);
        int n;
        n = 0;
        while (slice_clk[idx] !== lvl && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask

    // Count the period that has just begun, in clk cycles high and low
    task automatic count_period(input int idx, output int h, output int l);
        h = 0;
        l = 0;
        while (slice_clk[idx] === 1'b1 && h < 3000) begin @(negedge clk); h++; end
        while (slice_clk[idx] === 1'b0 && l < 3000) begin @(negedge clk); l++; end
    endtask

    // Skip to the next rising output edge, then count that whole period
    task automatic measure(input int idx, output int h, output int l);
        wait_lvl(idx, 1'b0);
        wait_lvl(idx, 1'b1);
        count_period(idx, h, l);
    endtask

    task automatic reset_values();
        `CHECK(wake_en_r, 8'hff)
        `CHECK(sleep_en_r, 8'hff)
        `CHECK(ref_selected, 2'h1)
        `CHECK(sys_selected, 2'h1)
        `CHECK(sys_sleep_r, 1'b0)
    endtask

    // Odd divide, duty correction, on-the-fly fraction, divide by one
    task automatic divider_ratios();
        ctrl[7].enable = 1'b1;
        ctrl[8].enable = 1'b1;
        ctrl[2].div = 32'h0000_0300;
        ctrl[2].enable = 1'b1;
        measure(2, hi, lo);
        measure(2, hi, lo);
        `CHECK(hi, 16)
        `CHECK(lo, 32)
        `CHECK(gpo_a, slice_clk[2])
        ctrl[2].dcc_en = 1'b1;
        measure(2, hi, lo);
        measure(2, hi, lo);
        `CHECK(hi, 24)
        `CHECK(hi + lo, 48)
        // Fraction 0.5 alternates 2 and 3 source periods: two periods sum to five
        ctrl[2].dcc_en = 1'b0;
        ctrl[2].div = 32'h0000_0280;
        measure(2, hi, lo);
        count_period(2, hi2, lo2);
        `CHECK(hi + lo + hi2 + lo2, 80)
        `CHECK((hi + lo == 32) || (hi + lo == 48), 1'b1)
        ctrl[2].div = 32'h0000_0100;
        measure(2, hi, lo);
        measure(2, hi, lo);
        `CHECK(hi + lo, 16)
    endtask

    // Disable stops cleanly; kill stops at once; both release again
    task automatic stop_controls();
        ctrl[2].div = 32'h0000_0300;
        measure(2, hi, lo);
        ctrl[2].enable = 1'b0;
        repeat (100) @(negedge clk);
        hi = 0;
        repeat (100) begin @(negedge clk); hi += int'(slice_clk[2]); end
        `CHECK(hi, 0)
        ctrl[2].aux_sel = 4'h1;
        ctrl[2].enable = 1'b1;
        measure(2, hi, lo);
        `CHECK(hi, 16)
        wait_lvl(2, 1'b1);
        ctrl[2].kill = 1'b1;
        repeat (3) @(negedge clk);
        `CHECK(slice_clk[2], 1'b0)
        ctrl[2].kill = 1'b0;
        measure(2, hi, lo);
        `CHECK(hi + lo, 48)
    endtask

    // Glitch-free switch reports its source; state_a stops the reference
    task automatic always_on();
        ctrl[0].aux_sel = 4'h1;
        ctrl[0].glitch_aux = 1'b1;
        repeat (80) @(negedge clk);
        `CHECK(ref_selected, 2'h2)
        measure(0, hi, lo);
        `CHECK(hi, 8)
        state_a_active = 1'b1;
        repeat (60) @(negedge clk);
        hi = 0;
        repeat (64) begin @(negedge clk); hi += int'(slice_clk[0]); end
        `CHECK(hi, 0)
        state_a_active = 1'b0;
        measure(0, hi, lo);
        `CHECK(hi + lo, 16)
    endtask

    // Awake and sleep enable selection
    task automatic sleep_gating();
        en_wdata = 8'h00;
        wake_en_wr = 1'b1;
        @(negedge clk);
        wake_en_wr = 1'b0;
        en_wdata = 8'h0c;
        sleep_en_wr = 1'b1;
        @(negedge clk);
        sleep_en_wr = 1'b0;
        repeat (3) @(negedge clk);
        `CHECK(dest_en_r, 8'h03)
        `CHECK(sleep_en_r, 8'h0c)
        core_sleep = 2'h3;
        dma_busy = 1'b1;
        repeat (3) @(negedge clk);
        `CHECK(sys_sleep_r, 1'b0)
        dma_busy = 1'b0;
        repeat (3) @(negedge clk);
        `CHECK(sys_sleep_r, 1'b1)
        `CHECK(dest_en_r, 8'h0c)
        // Two whole system clock periods: gated bit silent, enabled bit and cores follow
        hi = 0;
        hi2 = 0;
        lo = 0;
        repeat (32) begin
            @(negedge clk);
            hi += int'(dest_clk_r[0]);
            hi2 += int'(dest_clk_r[2]);
            lo += int'(core_clk_r);
        end
        `CHECK(hi, 0)
        `CHECK(hi2, 16)
        `CHECK(lo, 16)
        core_sleep = 2'h1;
        repeat (3) @(negedge clk);
        `CHECK(dest_en_r, 8'h03)
        measure(7, hi, lo);
        `CHECK(hi + lo, 16)
        measure(8, hi2, lo2);
        `CHECK(hi2 + lo2, 16)
    endtask

    initial begin
        for (int i = 0; i < clock_gen_pkg::NSL; i++) begin
            ctrl[i] = '0;
            ctrl[i].div = 32'h0000_0100;
        end
        repeat (4) @(negedge clk);
        reset_values();
        reset_n = 1'b1;
        divider_ratios();
        stop_controls();
        always_on();
        sleep_gating();
        print_verdict();
    end
endmodule

`default_nettype wire
